// ==== hw/mcuex_core.sv ====
/*
 Execute core: arithmetic, logic, compare, jump, call, return, skip,
 branch and I/O bit instructions, plus status flags and stack pointer.
 Assumes decoded instructions with operand values, a stack memory with
 one cycle read latency and an I/O space that honours a per-bit write mask.
*/
// What this block does
// - Add with carry stores Rd+Rr+C, updates Z C N V H, one cycle.
// - Word add/minus on a register pair, updates Z C N V S, two cycles.
// - Minus with carry stores Rd-K-C, updates Z C N V H, one cycle.
// - AND, OR, XOR update only Z N V; carry kept; one cycle.
// - Clear mask ANDs with complement of K; set mask ORs with K.
// - Relative jump to PC+k+1, indirect jump to Z; two cycles, no flags.
// - Calls take three cycles, returns take four.
// - Compare-skip-equal skips next instruction when equal; 1, 2 or 3 cycles.
// - Compares compute the difference without storing; update Z N V C H.
// - Register bit skips skip when the bit is clear or set.
// - I/O bit skips skip when the I/O bit is clear or set.
// - Flag branches load PC+k+1 when taken; 1 cycle or 2.
// - Signed branches decide on N xor V.
// - Unsigned same-or-higher and lower branches test carry clear or set.
// - Interrupt-state branches test the global interrupt enable flag.
// - I/O bit set and clear force one bit; two cycles, no flags.
// - Bit operations on I/O work only at addresses 0x00 to 0x1F.
// - A bit set or clear writes only the addressed bit.
// - Write-one-to-clear neighbours see zero during bit writes.
`timescale 1ns/1ps
module mcuex_core #(
   parameter int PC_W = 12
) (
   input  logic                       clk_i,
   input  logic                       resetn_i,
   input  logic                       instr_valid_i,
   input  mcuex_pkg::mcuex_instr_type instr_i,
   input  logic [7:0]                 mem_rdata_i,
   input  logic [5:0]                 sfr_addr_i,
   input  logic                       sfr_we_i,
   input  logic [7:0]                 sfr_wdata_i,
   output logic                       ready_o,
   output logic [PC_W-1:0]            pc_o,
   output mcuex_pkg::mcuex_res_type   res_o,
   output mcuex_pkg::mcuex_io_type    io_o,
   output mcuex_pkg::mcuex_mem_type   mem_o,
   output logic [7:0]                 status_o,
   output logic [7:0]                 sfr_rdata_o
);

   // ---------------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_RUN, S_WAIT, S_PUSH_HI, S_POP_LO, S_POP_CAP_HI, S_POP_CAP_LO
   } mcuex_state_type;

   mcuex_state_type              state_q;
   logic                         ready_q;
   logic [1:0]                   cnt_q;
   logic [PC_W-1:0]              pc_q;
   logic [15:0]                  ret_q;
   logic [9:0]                   sp_q;
   logic [7:0]                   status_q;
   mcuex_pkg::mcuex_res_type     res_q;
   mcuex_pkg::mcuex_io_type      io_q;
   mcuex_pkg::mcuex_mem_type     mem_q;
   logic [7:0]                   sfr_rdata_q;

   mcuex_pkg::mcuex_instr_type   ins;
   logic                         accept;
   logic [7:0]                   a;
   logic [7:0]                   b;
   logic [7:0]                   r;
   logic [8:0]                   add9;
   logic [8:0]                   sub9;
   logic [15:0]                  wres;
   logic [7:0]                   flg_d;
   logic                         wr_en;
   logic                         wide;
   logic                         set_nz;
   logic                         keep_z;
   logic                         skip;
   logic                         taken;
   logic                         bit_io;
   logic                         call_req;
   logic                         ret_req;
   logic [1:0]                   extra;
   logic [PC_W-1:0]              pc_inc;
   logic [PC_W-1:0]              pc_rel;
   logic [PC_W-1:0]              pc_n;

   assign ins    = instr_i;
   assign accept = instr_valid_i & ready_q;
   assign pc_inc = pc_q + PC_W'(1);
   assign pc_rel = pc_inc + PC_W'(ins.offset);
   assign bit_io = ins.io_addr <= mcuex_pkg::BIT_IO_LAST;

   // ---------------------------------------------------------------------
   // Execute
   // ---------------------------------------------------------------------
   always_comb begin
      a        = ins.rd_val;
      b        = ins.use_imm ? ins.imm : ins.rr_val;
      add9     = {1'b0, a} + {1'b0, b} + {8'h00, status_q[mcuex_pkg::FLAG_C] & (ins.op == mcuex_pkg::OP_ADD_CARRY)};
      sub9     = {1'b0, a} - {1'b0, b} - {8'h00, status_q[mcuex_pkg::FLAG_C] &
                 (ins.op == mcuex_pkg::OP_MINUS_CARRY || ins.op == mcuex_pkg::OP_CMP_CARRY)};
      r        = 8'h00;
      wres     = 16'h0000;
      flg_d    = status_q;
      wr_en    = 1'b0;
      wide     = 1'b0;
      set_nz   = 1'b0;
      keep_z   = 1'b0;
      skip     = 1'b0;
      taken    = 1'b0;
      call_req = 1'b0;
      ret_req  = 1'b0;
      extra    = 2'h0;
      pc_n     = pc_inc;
      case (ins.op)
         mcuex_pkg::OP_ADD, mcuex_pkg::OP_ADD_CARRY: begin
            r      = add9[7:0];
            wr_en  = 1'b1;
            set_nz = 1'b1;
            flg_d[mcuex_pkg::FLAG_H] = a[3] & b[3] | b[3] & ~r[3] | ~r[3] & a[3];
            flg_d[mcuex_pkg::FLAG_V] = a[7] & b[7] & ~r[7] | ~a[7] & ~b[7] & r[7];
            flg_d[mcuex_pkg::FLAG_C] = add9[8];
         end
         mcuex_pkg::OP_MINUS, mcuex_pkg::OP_MINUS_CARRY, mcuex_pkg::OP_CMP, mcuex_pkg::OP_CMP_CARRY: begin
            r      = sub9[7:0];
            wr_en  = ins.op == mcuex_pkg::OP_MINUS || ins.op == mcuex_pkg::OP_MINUS_CARRY;
            set_nz = 1'b1;
            keep_z = ins.op == mcuex_pkg::OP_MINUS_CARRY || ins.op == mcuex_pkg::OP_CMP_CARRY;
            flg_d[mcuex_pkg::FLAG_H] = ~a[3] & b[3] | b[3] & r[3] | r[3] & ~a[3];
            flg_d[mcuex_pkg::FLAG_V] = a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7];
            flg_d[mcuex_pkg::FLAG_C] = sub9[8];
         end
         mcuex_pkg::OP_AND, mcuex_pkg::OP_OR, mcuex_pkg::OP_XOR, mcuex_pkg::OP_CLEAR_MASK: begin
            if (ins.op == mcuex_pkg::OP_AND) begin
               r = a & b;
            end else if (ins.op == mcuex_pkg::OP_OR) begin
               r = a | b;
            end else if (ins.op == mcuex_pkg::OP_XOR) begin
               r = a ^ b;
            end else begin
               r = a & ~ins.imm;
            end
            wr_en  = 1'b1;
            set_nz = 1'b1;
            flg_d[mcuex_pkg::FLAG_V] = 1'b0;
         end
         mcuex_pkg::OP_WORD_ADD, mcuex_pkg::OP_WORD_MINUS: begin
            if (ins.op == mcuex_pkg::OP_WORD_ADD) begin
               wres = {ins.rd_hi_val, a} + {10'h000, ins.imm[5:0]};
               flg_d[mcuex_pkg::FLAG_V] = ~ins.rd_hi_val[7] & wres[15];
               flg_d[mcuex_pkg::FLAG_C] = ins.rd_hi_val[7] & ~wres[15];
            end else begin
               wres = {ins.rd_hi_val, a} - {10'h000, ins.imm[5:0]};
               flg_d[mcuex_pkg::FLAG_V] = ins.rd_hi_val[7] & ~wres[15];
               flg_d[mcuex_pkg::FLAG_C] = ~ins.rd_hi_val[7] & wres[15];
            end
            wr_en = 1'b1;
            wide  = 1'b1;
            extra = mcuex_pkg::EXTRA_TWO;
            flg_d[mcuex_pkg::FLAG_N] = wres[15];
            flg_d[mcuex_pkg::FLAG_Z] = wres == 16'h0000;
            flg_d[mcuex_pkg::FLAG_S] = wres[15] ^ flg_d[mcuex_pkg::FLAG_V];
         end
         mcuex_pkg::OP_REL_JUMP, mcuex_pkg::OP_IND_JUMP: begin
            pc_n  = ins.op == mcuex_pkg::OP_REL_JUMP ? pc_rel : PC_W'(ins.z_ptr);
            extra = mcuex_pkg::EXTRA_TWO;
         end
         mcuex_pkg::OP_REL_CALL, mcuex_pkg::OP_PTR_CALL: begin
            pc_n     = ins.op == mcuex_pkg::OP_REL_CALL ? pc_rel : PC_W'(ins.z_ptr);
            call_req = 1'b1;
         end
         mcuex_pkg::OP_CALL_EXIT, mcuex_pkg::OP_IRQ_EXIT: begin
            ret_req = 1'b1;
            if (ins.op == mcuex_pkg::OP_IRQ_EXIT) begin
               flg_d[mcuex_pkg::FLAG_I] = 1'b1;
            end
         end
         mcuex_pkg::OP_CMP_SKIP_EQ:   skip = a == ins.rr_val;
         mcuex_pkg::OP_SKIP_REG_LOW:  skip = ~ins.rr_val[ins.bit_sel];
         mcuex_pkg::OP_SKIP_REG_HIGH: skip = ins.rr_val[ins.bit_sel];
         mcuex_pkg::OP_SKIP_IO_LOW:   skip = bit_io & ~ins.io_val[ins.bit_sel];
         mcuex_pkg::OP_SKIP_IO_HIGH:  skip = bit_io & ins.io_val[ins.bit_sel];
         mcuex_pkg::OP_BR_FLAG_SET, mcuex_pkg::OP_BR_FLAG_CLEAR: begin
            // Carry selects same-or-higher and lower; the I flag selects the interrupt-state tests.
            taken = status_q[ins.flag_sel];
            if (int'(ins.flag_sel) == mcuex_pkg::FLAG_S) begin
               taken = status_q[mcuex_pkg::FLAG_N] ^ status_q[mcuex_pkg::FLAG_V];
            end
            if (ins.op == mcuex_pkg::OP_BR_FLAG_CLEAR) begin
               taken = ~taken;
            end
            if (taken) begin
               pc_n  = pc_rel;
               extra = mcuex_pkg::EXTRA_TWO;
            end
         end
         mcuex_pkg::OP_IO_SET, mcuex_pkg::OP_IO_CLEAR: extra = mcuex_pkg::EXTRA_TWO;
         default: pc_n = pc_inc;
      endcase
      if (skip) begin
         pc_n  = ins.next_long ? pc_inc + PC_W'(2) : pc_inc + PC_W'(1);
         extra = ins.next_long ? mcuex_pkg::EXTRA_THREE : mcuex_pkg::EXTRA_TWO;
      end
      if (set_nz) begin
         flg_d[mcuex_pkg::FLAG_N] = r[7];
         flg_d[mcuex_pkg::FLAG_Z] = (r == 8'h00) & (~keep_z | status_q[mcuex_pkg::FLAG_Z]);
      end
      if (!wide) begin
         wres = {8'h00, r};
      end
   end

   // ---------------------------------------------------------------------
   // Sequencing
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= S_RUN;
         ready_q <= 1'b1;
         cnt_q   <= 2'h0;
      end else begin
         case (state_q)
            S_RUN: begin
               if (accept && call_req) begin
                  state_q <= S_PUSH_HI;
                  ready_q <= 1'b0;
               end else if (accept && ret_req) begin
                  state_q <= S_POP_LO;
                  ready_q <= 1'b0;
               end else if (accept && extra != 2'h0) begin
                  state_q <= S_WAIT;
                  cnt_q   <= extra - 2'h1;
                  ready_q <= 1'b0;
               end
            end
            S_PUSH_HI: begin
               state_q <= S_WAIT;
               cnt_q   <= 2'h0;
            end
            S_POP_LO:     state_q <= S_POP_CAP_HI;
            S_POP_CAP_HI: state_q <= S_POP_CAP_LO;
            S_POP_CAP_LO: begin
               state_q <= S_RUN;
               ready_q <= 1'b1;
            end
            S_WAIT: begin
               if (cnt_q == 2'h0) begin
                  state_q <= S_RUN;
                  ready_q <= 1'b1;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            default: begin
               state_q <= S_RUN;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------------
   // Program counter and return address
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pc_q  <= '0;
         ret_q <= 16'h0000;
      end else if (accept) begin
         pc_q  <= pc_n;
         ret_q <= 16'(pc_inc);
      end else if (state_q == S_POP_CAP_HI) begin
         ret_q[15:8] <= mem_rdata_i;
      end else if (state_q == S_POP_CAP_LO) begin
         pc_q <= PC_W'({ret_q[15:8], mem_rdata_i});
      end
   end

   // ---------------------------------------------------------------------
   // Stack pointer and stack memory
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sp_q <= mcuex_pkg::SP_RESET;
      end else if (sfr_we_i && sfr_addr_i == mcuex_pkg::SP_HIGH_OFS) begin
         sp_q[9:8] <= sfr_wdata_i[1:0];
      end else if (sfr_we_i && sfr_addr_i == mcuex_pkg::SP_LOW_OFS) begin
         sp_q[7:0] <= sfr_wdata_i;
      end else if ((accept && call_req) || state_q == S_PUSH_HI) begin
         sp_q <= sp_q - 10'h001;
      end else if ((accept && ret_req) || state_q == S_POP_LO) begin
         sp_q <= sp_q + 10'h001;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mem_q <= '0;
      end else begin
         mem_q <= '0;
         if (accept && call_req) begin
            mem_q.we    <= 1'b1;
            mem_q.addr  <= sp_q;
            mem_q.wdata <= pc_inc[7:0];
         end else if (state_q == S_PUSH_HI) begin
            mem_q.we    <= 1'b1;
            mem_q.addr  <= sp_q;
            mem_q.wdata <= ret_q[15:8];
         end else if ((accept && ret_req) || state_q == S_POP_LO) begin
            mem_q.re   <= 1'b1;
            mem_q.addr <= sp_q + 10'h001;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Status flags and results
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_q <= mcuex_pkg::STATUS_RESET;
      end else if (sfr_we_i && sfr_addr_i == mcuex_pkg::STATUS_FLAGS_OFS) begin
         status_q <= sfr_wdata_i;
      end else if (accept) begin
         status_q <= flg_d;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         res_q <= '0;
      end else begin
         res_q.we   <= accept & wr_en;
         res_q.word <= wide;
         res_q.data <= wres;
      end
   end

   // ---------------------------------------------------------------------
   // I/O bit writes
   // ---------------------------------------------------------------------
   // Only the addressed bit is in the mask and every other data bit is zero,
   // so write-one-to-clear flags beside it are never cleared by accident.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         io_q <= '0;
      end else begin
         io_q.we    <= accept & bit_io & (ins.op == mcuex_pkg::OP_IO_SET || ins.op == mcuex_pkg::OP_IO_CLEAR);
         io_q.addr  <= ins.io_addr;
         io_q.wmask <= 8'h01 << ins.bit_sel;
         io_q.wdata <= ins.op == mcuex_pkg::OP_IO_SET ? 8'h01 << ins.bit_sel : 8'h00;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sfr_rdata_q <= 8'h00;
      end else begin
         case (sfr_addr_i)
            mcuex_pkg::STATUS_FLAGS_OFS: sfr_rdata_q <= status_q;
            mcuex_pkg::SP_HIGH_OFS:      sfr_rdata_q <= {6'h00, sp_q[9:8]};
            mcuex_pkg::SP_LOW_OFS:       sfr_rdata_q <= sp_q[7:0];
            default:                     sfr_rdata_q <= 8'h00;
         endcase
      end
   end

   assign ready_o     = ready_q;
   assign pc_o        = pc_q;
   assign res_o       = res_q;
   assign io_o        = io_q;
   assign mem_o       = mem_q;
   assign status_o    = status_q;
   assign sfr_rdata_o = sfr_rdata_q;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   AST_ADD_CARRY: assert property (accept && ins.op == mcuex_pkg::OP_ADD_CARRY |=>
      res_o.we && res_o.data[7:0] == 8'($past(a) + $past(b) + $past(status_q[mcuex_pkg::FLAG_C])))
      else $error("add with carry result wrong");
   AST_WORD_TWO: assert property (accept && wide |=> !ready_o && res_o.word ##1 ready_o)
      else $error("word operation not two cycles");
   AST_LOGIC_CARRY: assert property (accept && !sfr_we_i && (ins.op == mcuex_pkg::OP_AND ||
      ins.op == mcuex_pkg::OP_XOR) |=> status_o[mcuex_pkg::FLAG_C] == $past(status_q[mcuex_pkg::FLAG_C]))
      else $error("logic operation changed carry");
   AST_CLEAR_MASK: assert property (accept && ins.op == mcuex_pkg::OP_CLEAR_MASK |=>
      res_o.data[7:0] == ($past(a) & ~$past(ins.imm)))
      else $error("clear mask result wrong");
   AST_JUMP: assert property (accept && ins.op == mcuex_pkg::OP_REL_JUMP |=>
      pc_o == $past(pc_rel) && !ready_o ##1 ready_o)
      else $error("relative jump wrong");
   AST_CALL_THREE: assert property (accept && call_req |=> !ready_o [*2] ##1 ready_o)
      else $error("call not three cycles");
   AST_RET_FOUR: assert property (accept && ret_req |=> !ready_o [*3] ##1 ready_o)
      else $error("return not four cycles");
   AST_CMP_NOSTORE: assert property (accept && ins.op == mcuex_pkg::OP_CMP |=> !res_o.we)
      else $error("compare stored a result");
   AST_BR_NOT_TAKEN: assert property (accept && (ins.op == mcuex_pkg::OP_BR_FLAG_SET ||
      ins.op == mcuex_pkg::OP_BR_FLAG_CLEAR) && !taken |=> ready_o && pc_o == $past(pc_inc))
      else $error("untaken branch wrong");
   AST_IO_MASK: assert property (io_o.we |-> $onehot(io_o.wmask) && (io_o.wdata & ~io_o.wmask) == 8'h00)
      else $error("bit write touches other bits");
   AST_IO_RANGE: assert property (io_o.we |-> io_o.addr <= mcuex_pkg::BIT_IO_LAST)
      else $error("bit write above bit range");
   AST_SP_HIGH: assert property (sfr_addr_i == mcuex_pkg::SP_HIGH_OFS |=> sfr_rdata_o[7:2] == 6'h00)
      else $error("stack pointer high bits not zero");

   COV_CALL: cover property (accept && call_req);
   COV_RET:  cover property (accept && ins.op == mcuex_pkg::OP_IRQ_EXIT);
   COV_SKIP: cover property (accept && skip && ins.next_long);
   COV_IO:   cover property (io_o.we && io_o.wdata != 8'h00);

endmodule // mcuex_core

// ==== hw/mcuex_pkg.sv ====
/*
 Shared constants and carrier types of the execute core.
 Assumes instructions arrive already decoded, with their operand values read.
*/
package mcuex_pkg;

   // --------------------------------------------------------------------
   // Register offsets in I/O space and reset values
   // --------------------------------------------------------------------
   localparam logic [5:0] STATUS_FLAGS_OFS = 6'h3f;
   localparam logic [5:0] SP_HIGH_OFS      = 6'h3e;
   localparam logic [5:0] SP_LOW_OFS       = 6'h3d;
   localparam logic [5:0] BIT_IO_LAST      = 6'h1f;
   localparam logic [7:0] STATUS_RESET     = 8'h00;
   localparam logic [9:0] SP_RESET         = 10'h000;

   // --------------------------------------------------------------------
   // Status flag positions
   // --------------------------------------------------------------------
   localparam int FLAG_I = 7;
   localparam int FLAG_H = 5;
   localparam int FLAG_S = 4;
   localparam int FLAG_V = 3;
   localparam int FLAG_N = 2;
   localparam int FLAG_Z = 1;
   localparam int FLAG_C = 0;

   // --------------------------------------------------------------------
   // Extra cycles beyond the first
   // --------------------------------------------------------------------
   localparam logic [1:0] EXTRA_TWO   = 2'h1;
   localparam logic [1:0] EXTRA_THREE = 2'h2;

   // --------------------------------------------------------------------
   // Types
   // --------------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ADD, OP_ADD_CARRY, OP_MINUS, OP_MINUS_CARRY, OP_AND, OP_OR, OP_XOR,
      OP_CLEAR_MASK, OP_WORD_ADD, OP_WORD_MINUS, OP_REL_JUMP, OP_IND_JUMP,
      OP_REL_CALL, OP_PTR_CALL, OP_CALL_EXIT, OP_IRQ_EXIT, OP_CMP_SKIP_EQ,
      OP_CMP, OP_CMP_CARRY, OP_SKIP_REG_LOW, OP_SKIP_REG_HIGH, OP_SKIP_IO_LOW,
      OP_SKIP_IO_HIGH, OP_BR_FLAG_SET, OP_BR_FLAG_CLEAR, OP_IO_SET, OP_IO_CLEAR,
      OP_OTHER
   } mcuex_op_type;

   typedef struct packed {
      mcuex_op_type op;
      logic         use_imm;
      logic [7:0]   rd_val;
      logic [7:0]   rr_val;
      logic [7:0]   rd_hi_val;
      logic [7:0]   imm;
      logic [2:0]   bit_sel;
      logic [2:0]   flag_sel;
      logic [11:0]  offset;
      logic [5:0]   io_addr;
      logic [7:0]   io_val;
      logic [15:0]  z_ptr;
      logic         next_long;
   } mcuex_instr_type;

   typedef struct packed {
      logic        we;
      logic        word;
      logic [15:0] data;
   } mcuex_res_type;

   typedef struct packed {
      logic [5:0] addr;
      logic       we;
      logic [7:0] wdata;
      logic [7:0] wmask;
   } mcuex_io_type;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [9:0] addr;
      logic [7:0] wdata;
   } mcuex_mem_type;

endpackage

// ==== test/mcuex_stack_model.sv ====
/*
 Stack memory model facing the core's memory port.
 Assumes reads answer one cycle after the read strobe.
*/
`timescale 1ns/1ps
module mcuex_stack_model (
   input  logic                     clk_i,
   input  mcuex_pkg::mcuex_mem_type mem_i,
   output logic [7:0]               rdata_o
);
   logic [7:0] ram [1024];
   initial rdata_o = 8'h00;
   // Outside a read the data line toggles so stale bytes are never mistaken for an answer.
   always @(posedge clk_i) begin
      if (mem_i.we) ram[mem_i.addr] <= mem_i.wdata;
      rdata_o <= mem_i.re ? ram[mem_i.addr] : ~rdata_o;
   end
endmodule // mcuex_stack_model

// ==== test/tb_mcu_instruction_execute_core.sv ====
/*
 Self-checking bench of the execute core with a stack memory model.
 Assumes the core package and the registered contract of the core.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_mcu_instruction_execute_core;
   logic clk_i = 0, resetn_i = 0, instr_valid_i = 0, sfr_we_i = 0, ready_o;
   logic [7:0] mem_rdata_i, status_o, sfr_rdata_o, a, b, sfr_wdata_i = 8'h00;
   logic [5:0] sfr_addr_i = 6'h00;
   logic [11:0] pc_o, pc, pc_save;
   logic [8:0] s;
   logic [4:0] h;
   logic [23:0] ev, ex, expq[$];
   mcuex_pkg::mcuex_instr_type instr_i = '0, ins;
   mcuex_pkg::mcuex_res_type res_o;
   mcuex_pkg::mcuex_io_type io_o;
   mcuex_pkg::mcuex_mem_type mem_o;
   int n_fail = 0, check_count = 0, i;
   always #10 clk_i = ~clk_i;
   mcuex_core #(.PC_W(12)) u_mcuex_core (.clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .mem_rdata_i(mem_rdata_i), .sfr_addr_i(sfr_addr_i), .sfr_we_i(sfr_we_i),
      .sfr_wdata_i(sfr_wdata_i), .ready_o(ready_o), .pc_o(pc_o), .res_o(res_o), .io_o(io_o), .mem_o(mem_o),
      .status_o(status_o), .sfr_rdata_o(sfr_rdata_o));
   mcuex_stack_model u_mcuex_stack_model (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));
   always @(negedge clk_i) begin
      if (resetn_i && (res_o.we || io_o.we)) begin
         ev = res_o.we ? {7'h00, res_o.word, (res_o.word ? res_o.data[15:8] : 8'h00), res_o.data[7:0]}
                       : {2'b10, io_o.addr, io_o.wmask, io_o.wdata};
         if (expq.size() == 0) ex = ~ev; else ex = expq.pop_front();
         `CHK("result", ex, ev)
      end
   end
   task automatic test_done;
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic sfr(input logic [5:0] ad, input logic [7:0] d, input logic wr);
      @(posedge clk_i); sfr_addr_i <= ad; sfr_wdata_i <= d; sfr_we_i <= wr;
      @(posedge clk_i); sfr_we_i <= 1'b0;
      #1;
   endtask
   task automatic run(input int cyc, input logic [11:0] npc);
      int n;
      n = 0;
      @(posedge clk_i); instr_valid_i <= 1'b1; instr_i <= ins;
      @(posedge clk_i); instr_valid_i <= 1'b0;
      #1;
      while (ready_o !== 1'b1 && n < 9) begin @(posedge clk_i); #1; n++; end
      if (n == 9) begin n_fail++; test_done(); end
      `CHK("cycles", cyc - 1, n)
      `CHK("pc", npc, pc_o)
      pc = npc;
   endtask
   initial begin
      void'($urandom(49));
      ins = '0; pc = 12'h000;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      sfr(6'h3e, 8'h00, 1'b0); `CHK("sp_high", 8'h00, sfr_rdata_o)
      sfr(6'h3e, 8'h03, 1'b1); sfr(6'h3e, 8'h00, 1'b0); `CHK("sp_high", 8'h03, sfr_rdata_o)
      sfr(6'h3d, 8'h10, 1'b1);
      for (i = 0; i < 4; i++) begin
         a = (i == 3) ? 8'hf0 : 8'($urandom); b = (i == 3) ? 8'h0f : 8'($urandom);
         sfr(6'h3f, {7'h00, i[0]}, 1'b1);
         s = {1'b0, a} + {1'b0, b} + 9'(i[0]); h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(i[0]);
         ins = '0; ins.op = mcuex_pkg::OP_ADD_CARRY; ins.rd_val = a; ins.rr_val = b;
         expq.push_back({16'h0000, s[7:0]});
         run(1, pc + 12'h001);
         `CHK("carry", s[8], status_o[mcuex_pkg::FLAG_C])
         `CHK("half", h[4], status_o[mcuex_pkg::FLAG_H])
         `CHK("zero", (s[7:0] == 8'h00), status_o[mcuex_pkg::FLAG_Z])
      end
      sfr(6'h3f, 8'h01, 1'b1);
      ins = '0; ins.op = mcuex_pkg::OP_AND; ins.rd_val = 8'h80; ins.rr_val = 8'hc0;
      expq.push_back(24'h000080); run(1, pc + 12'h001); `CHK("status", 8'h05, status_o)
      ins.op = mcuex_pkg::OP_CLEAR_MASK; ins.use_imm = 1'b1; ins.imm = 8'h0f; ins.rd_val = 8'h3c;
      expq.push_back(24'h000030); run(1, pc + 12'h001); `CHK("status", 8'h01, status_o)
      ins = '0; ins.op = mcuex_pkg::OP_WORD_ADD; ins.rd_hi_val = 8'h12; ins.rd_val = 8'hff; ins.imm = 8'h01;
      expq.push_back(24'h011300); run(2, pc + 12'h001); `CHK("carry", 1'b0, status_o[0])
      ins = '0; ins.op = mcuex_pkg::OP_BR_FLAG_SET; ins.offset = 12'h010;
      run(1, pc + 12'h001);
      ins.op = mcuex_pkg::OP_BR_FLAG_CLEAR; run(2, pc + 12'h011);
      ins = '0; ins.op = mcuex_pkg::OP_REL_CALL; ins.offset = 12'h100; pc_save = pc;
      run(3, pc + 12'h101); ins.op = mcuex_pkg::OP_CALL_EXIT; run(4, pc_save + 12'h001);
      ins = '0; ins.op = mcuex_pkg::OP_IO_SET; ins.io_addr = 6'h1f; ins.bit_sel = 3'h3;
      expq.push_back({2'b10, 6'h1f, 8'h08, 8'h08}); run(2, pc + 12'h001);
      ins.op = mcuex_pkg::OP_IO_CLEAR; ins.io_addr = 6'h20; run(2, pc + 12'h001);
      ins.op = mcuex_pkg::OP_SKIP_IO_HIGH; ins.io_val = 8'hff; run(1, pc + 12'h001);
      ins = '0; ins.op = mcuex_pkg::OP_SKIP_REG_HIGH; ins.rr_val = 8'h20; ins.bit_sel = 3'h5; ins.next_long = 1'b1;
      run(3, pc + 12'h003);
      ins = '0; ins.op = mcuex_pkg::OP_REL_JUMP; ins.offset = 12'h020; run(2, pc + 12'h021);
      ins.op = mcuex_pkg::OP_IND_JUMP; ins.z_ptr = 16'h0040; run(2, 12'h040);
      ins.op = mcuex_pkg::OP_PTR_CALL; ins.z_ptr = 16'h0200; pc_save = pc; run(3, 12'h200);
      ins.op = mcuex_pkg::OP_IRQ_EXIT; run(4, pc_save + 12'h001);
      `CHK("irq", 1'b1, status_o[mcuex_pkg::FLAG_I])
      ins = '0; ins.op = mcuex_pkg::OP_BR_FLAG_SET; ins.flag_sel = 3'h7; ins.offset = 12'h004; run(2, pc + 12'h005);
      sfr(6'h3f, 8'h03, 1'b1); ins = '0; ins.op = mcuex_pkg::OP_MINUS_CARRY; ins.rd_val = 8'h05; ins.rr_val = 8'h04;
      expq.push_back(24'h000000); run(1, pc + 12'h001); `CHK("status", 8'h02, status_o)
      ins.op = mcuex_pkg::OP_CMP; ins.rd_val = 8'h10; ins.rr_val = 8'h20; run(1, pc + 12'h001);
      `CHK("status", 8'h05, status_o)
      ins = '0; ins.op = mcuex_pkg::OP_BR_FLAG_SET; ins.flag_sel = 3'h4; ins.offset = 12'h008; run(2, pc + 12'h009);
      ins = '0; ins.op = mcuex_pkg::OP_CMP_SKIP_EQ; ins.rd_val = 8'h5a; ins.rr_val = 8'h5a; run(2, pc + 12'h002);
      ins.op = mcuex_pkg::OP_SKIP_REG_LOW; ins.rr_val = 8'hfe; ins.bit_sel = 3'h0; run(2, pc + 12'h002);
      repeat (2) @(posedge clk_i);
      `CHK("pending", 0, expq.size())
      test_done();
   end
endmodule // tb_mcu_instruction_execute_core
